// >>> shared/smps_defs.svh
// Purpose: constants for the strap mode pin select block
// Assumes: four-level straps arrive already resolved to a 2-bit level code
// Notes: definitions only
`ifndef SMPS_DEFS_SVH
`define SMPS_DEFS_SVH
// Four-level strap codes
`define SMPS_LVL_ZERO 2'h0
`define SMPS_LVL_R 2'h1
`define SMPS_LVL_FLOAT 2'h2
`define SMPS_LVL_ONE 2'h3
// Resolved level, gain and address widths and strap count
`define SMPS_LVL_W 2
`define SMPS_GAIN_W 4
`define SMPS_ADDR_W 4
`define SMPS_NUM_STRAPS 5
// Strap slots in the capture memory
`define SMPS_SLOT_MODE 3'h0
`define SMPS_SLOT_DP_HI 3'h1
`define SMPS_SLOT_DP_LO 3'h2
`define SMPS_SLOT_US_HI 3'h3
`define SMPS_SLOT_US_LO 3'h4
// Reset value of captured straps
`define SMPS_STRAP_RST 2'h0
`endif

// >>> shared/smps_pkg.sv
// Purpose: types for the strap mode pin select block
// Assumes: constants come from smps_defs.svh
// Notes: none
`include "smps_defs.svh"
package smps_pkg;
  typedef enum logic [1:0] {
    SMPS_MODE_PIN,
    SMPS_MODE_TEST,
    SMPS_MODE_I2C_LOW_V,
    SMPS_MODE_I2C_HIGH_V
  } smps_mode_t;
  typedef logic [`SMPS_LVL_W-1:0] smps_lvl_t;
endpackage

// >>> shared/smps_strap_if.sv
// Purpose: carries strap capture between top and the strap store
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ps
`include "smps_defs.svh"
interface smps_strap_if;
  import smps_pkg::*;
  logic capture;
  smps_lvl_t live [`SMPS_NUM_STRAPS];
  smps_lvl_t held [`SMPS_NUM_STRAPS];
  modport ctrl (output capture, output live, input held);
  modport store (input capture, input live, output held);
endinterface

// >>> hw/smps_strap_store.sv
// Purpose: holds the strap levels captured at each enable rise
// Assumes: capture is a one-cycle pulse
// Notes: read data come straight from registers
`timescale 1ns/1ps
`include "smps_defs.svh"
module smps_strap_store
  import smps_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Strap carrier
  smps_strap_if.store sif
);
  smps_lvl_t mem [`SMPS_NUM_STRAPS];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `SMPS_NUM_STRAPS; i++) begin
        mem[i] <= `SMPS_STRAP_RST;
      end
    end else if (sif.capture) begin
      for (int i = 0; i < `SMPS_NUM_STRAPS; i++) begin
        mem[i] <= sif.live[i];
      end
    end
  end

  assign sif.held = mem;
endmodule

// >>> hw/smps_top.sv
// Purpose: strap decoding and dual-use pin selection of a Type-C sink switch
// Assumes: straps arrive as resolved level codes synchronous to clk_in
// Notes: I2C transport is outside; it delivers register bits as plain ports
`timescale 1ns/1ps
`include "smps_defs.svh"
module smps_top
  import smps_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Enable and straps
  input wire logic enable_in,
  input wire logic [1:0] mode_strap_in,
  input wire logic [1:0] dp_gain_strap_hi_in,
  input wire logic [1:0] dp_gain_strap_lo_addr_hi_in,
  input wire logic [1:0] usb_down_gain_strap_hi_in,
  input wire logic [1:0] usb_down_gain_strap_lo_addr_lo_in,
  // Dual-use pins
  input wire logic flip_scl_in,
  input wire logic usb_path_control_sda_in,
  input wire logic dp_path_control_in,
  // Register state from the I2C side
  input wire logic reg_flip_in,
  input wire logic reg_usb_en_in,
  input wire logic reg_dp_en_in,
  // AUX and sideband pins
  input wire logic aux_pair_pos_in,
  input wire logic aux_pair_neg_in,
  output logic sbu1_out,
  output logic sbu2_out,
  // Decoded state
  output smps_mode_t mode_out,
  output logic i2c_active_out,
  output logic i2c_scl_out,
  output logic i2c_sda_out,
  output logic [`SMPS_ADDR_W-1:0] i2c_addr_out,
  output logic flip_out,
  output logic usb_en_out,
  output logic dp_en_out,
  output logic [`SMPS_GAIN_W-1:0] dp_gain_out,
  output logic [`SMPS_GAIN_W-1:0] usb_down_gain_out,
  output logic aux_snoop_out,
  output logic aux_snoop_pos_out,
  output logic aux_snoop_neg_out
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // Strap capture
  // ****************************************
  // Only the enable rise captures; the I2C register ports are untouched
  logic enable_q;
  wire enable_rise = enable_in & ~enable_q;
  smps_strap_if sif ();

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= enable_in;
    end
  end

  assign sif.capture = enable_rise;
  assign sif.live[`SMPS_SLOT_MODE] = mode_strap_in;
  assign sif.live[`SMPS_SLOT_DP_HI] = dp_gain_strap_hi_in;
  assign sif.live[`SMPS_SLOT_DP_LO] = dp_gain_strap_lo_addr_hi_in;
  assign sif.live[`SMPS_SLOT_US_HI] = usb_down_gain_strap_hi_in;
  assign sif.live[`SMPS_SLOT_US_LO] = usb_down_gain_strap_lo_addr_lo_in;

  smps_strap_store i_smps_strap_store (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .sif(sif)
  );

  // ****************************************
  // Decode
  // ****************************************
  function automatic smps_mode_t decode_mode(input smps_lvl_t lvl);
    smps_mode_t m;
    m = SMPS_MODE_PIN;
    unique case (lvl)
      `SMPS_LVL_ZERO: m = SMPS_MODE_PIN;
      `SMPS_LVL_R: m = SMPS_MODE_TEST;
      `SMPS_LVL_FLOAT: m = SMPS_MODE_I2C_LOW_V;
      `SMPS_LVL_ONE: m = SMPS_MODE_I2C_HIGH_V;
    endcase
    return m;
  endfunction

  // Two four-level straps form a 16-entry selection
  function automatic logic [`SMPS_GAIN_W-1:0] pair_code(input smps_lvl_t hi, input smps_lvl_t lo);
    return {hi, lo};
  endfunction

  wire smps_mode_t next_mode = decode_mode(sif.held[`SMPS_SLOT_MODE]);
  wire pin_mode = (next_mode == SMPS_MODE_PIN);
  wire next_flip = pin_mode ? flip_scl_in : reg_flip_in;
  wire next_usb_en = pin_mode ? usb_path_control_sda_in : reg_usb_en_in;
  wire next_dp_en = pin_mode ? dp_path_control_in : reg_dp_en_in;
  wire [`SMPS_ADDR_W-1:0] next_addr =
    pair_code(sif.held[`SMPS_SLOT_DP_LO], sif.held[`SMPS_SLOT_US_LO]);
  wire [`SMPS_GAIN_W-1:0] next_dp_gain =
    pair_code(sif.held[`SMPS_SLOT_DP_HI], sif.held[`SMPS_SLOT_DP_LO]);
  wire [`SMPS_GAIN_W-1:0] next_us_gain =
    pair_code(sif.held[`SMPS_SLOT_US_HI], sif.held[`SMPS_SLOT_US_LO]);
  // Snoop only makes sense when the AUX path is wired and registers reach it
  wire next_snoop = ~pin_mode;
  wire next_sbu1 = next_flip ? aux_pair_neg_in : aux_pair_pos_in;
  wire next_sbu2 = next_flip ? aux_pair_pos_in : aux_pair_neg_in;

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mode_out <= SMPS_MODE_PIN;
      i2c_active_out <= 1'b0;
      i2c_scl_out <= 1'b1;
      i2c_sda_out <= 1'b1;
      i2c_addr_out <= '0;
      flip_out <= 1'b0;
      usb_en_out <= 1'b0;
      dp_en_out <= 1'b0;
      dp_gain_out <= '0;
      usb_down_gain_out <= '0;
      aux_snoop_out <= 1'b0;
      aux_snoop_pos_out <= 1'b0;
      aux_snoop_neg_out <= 1'b0;
      sbu1_out <= 1'b0;
      sbu2_out <= 1'b0;
    end else begin
      mode_out <= next_mode;
      i2c_active_out <= ~pin_mode;
      i2c_scl_out <= pin_mode ? 1'b1 : flip_scl_in;
      i2c_sda_out <= pin_mode ? 1'b1 : usb_path_control_sda_in;
      i2c_addr_out <= pin_mode ? '0 : next_addr;
      flip_out <= next_flip;
      usb_en_out <= next_usb_en;
      dp_en_out <= next_dp_en;
      dp_gain_out <= next_dp_gain;
      usb_down_gain_out <= next_us_gain;
      aux_snoop_out <= next_snoop;
      aux_snoop_pos_out <= aux_pair_pos_in;
      aux_snoop_neg_out <= aux_pair_neg_in;
      sbu1_out <= next_sbu1;
      sbu2_out <= next_sbu2;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Checks start one edge after reset release, so $past never sees reset-time inputs
  logic chk_on;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      chk_on <= 1'b0;
    end else begin
      chk_on <= 1'b1;
    end
  end

  sequence pin_mode_s;
    sif.held[`SMPS_SLOT_MODE] == `SMPS_LVL_ZERO;
  endsequence
  sequence i2c_mode_s;
    sif.held[`SMPS_SLOT_MODE] != `SMPS_LVL_ZERO;
  endsequence

  flip_pin_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    pin_mode_s |=> flip_out == $past(flip_scl_in)) else $error("flip not from pin");
  path_pin_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    pin_mode_s |=> usb_en_out == $past(usb_path_control_sda_in)) else $error("usb path bad");
  dp_pin_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    pin_mode_s |=> dp_en_out == $past(dp_path_control_in)) else $error("dp pin bad");
  dp_reg_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    i2c_mode_s |=> dp_en_out == $past(reg_dp_en_in)) else $error("dp reg bad");
  addr_straps_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    i2c_mode_s |=> i2c_addr_out ==
      $past({sif.held[`SMPS_SLOT_DP_LO], sif.held[`SMPS_SLOT_US_LO]}))
    else $error("address bad");
  dp_gain_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    ##1 dp_gain_out == $past({sif.held[1], sif.held[2]})) else $error("dp gain bad");
  usb_gain_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    ##1 usb_down_gain_out == $past({sif.held[3], sif.held[4]})) else $error("usb gain bad");
  aux_route_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    ##1 sbu1_out == (flip_out ? $past(aux_pair_neg_in) : $past(aux_pair_pos_in)) &&
      sbu2_out == (flip_out ? $past(aux_pair_pos_in) : $past(aux_pair_neg_in)))
    else $error("aux route bad");
  mode_decode_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    ##1 i2c_active_out == ($past(sif.held[0]) != `SMPS_LVL_ZERO) &&
      mode_out == $past(sif.held[0]))
    else $error("mode bad");
  strap_sample_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    enable_rise ##1 1'b1 |-> sif.held[0] == $past(mode_strap_in)) else $error("no sample");
  strap_hold_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    !enable_rise |=> $stable(sif.held[0])) else $error("strap changed");
  swap_reg_a: assert property (@(posedge clk_in) disable iff (!chk_on)
    i2c_mode_s |=> flip_out == $past(reg_flip_in) && usb_en_out == $past(reg_usb_en_in))
    else $error("swap reg bad");
endmodule

// >>> bench/smps_board_model.sv
// Purpose: board straps seen by the strap mode pin select block
// Assumes: bench asks for levels; the board keeps its own wiring limits
// Notes: strap levels only, no I2C traffic
`timescale 1ns/1ps
`include "smps_defs.svh"
module smps_board_model
  import smps_pkg::*;
(
  // Requested levels
  input wire logic [1:0] mode_req_in,
  input wire logic [1:0] usb_lo_req_in,
  // Levels on the board
  output logic [1:0] mode_strap_out,
  output logic [1:0] usb_lo_strap_out
);
  wire float_mode;
  wire usb_lo_legal;
  assign float_mode = mode_req_in == `SMPS_LVL_FLOAT;
  assign usb_lo_legal = usb_lo_req_in == `SMPS_LVL_FLOAT || usb_lo_req_in == `SMPS_LVL_ZERO;
  // Float mode leaves only float or zero on the low USB strap
  assign usb_lo_strap_out = (float_mode && !usb_lo_legal) ? `SMPS_LVL_FLOAT : usb_lo_req_in;
  assign mode_strap_out = mode_req_in;
endmodule

// >>> bench/tb_smps_top.sv
// Purpose: self-checking bench for the strap mode pin select block
// Assumes: straps settle before each enable rise
// Notes: expectations queued by the driver, compared by a watcher
`timescale 1ns/1ps
`include "smps_defs.svh"
module tb_smps_top;
  import smps_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic enable_in = 1'b0;
  logic [1:0] mode_req = 2'h0, usb_lo_req = 2'h0, dp_hi = 2'h0, dp_lo = 2'h0, us_hi = 2'h0;
  logic [1:0] mode_strap, usb_lo_strap;
  logic [1:0] cap_m = 2'h0, cap_dh = 2'h0, cap_dl = 2'h0, cap_uh = 2'h0, cap_ul = 2'h0;
  logic flip_pin = 1'b0, sda_pin = 1'b0, dp_pin = 1'b0, ax_p = 1'b0, ax_n = 1'b0;
  logic r_flip = 1'b0, r_usb = 1'b0, r_dp = 1'b0;
  logic sbu1, sbu2, i2c_act, scl, sda, flip, usb_en, dp_en, snoop, snp_p, snp_n;
  smps_mode_t mode;
  logic [3:0] addr, dp_gain, us_gain;
  logic [31:0] seed = 32'h80E35577;
  logic [24:0] notes [$];
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  event sample_ev;
  wire [24:0] seen = {mode, i2c_act, scl, sda, addr, flip, usb_en, dp_en, dp_gain, us_gain,
                      snoop, sbu1, sbu2, snp_p, snp_n};

  always #2 clk_in = ~clk_in;

  smps_board_model i_smps_board_model (.mode_req_in(mode_req), .usb_lo_req_in(usb_lo_req),
    .mode_strap_out(mode_strap), .usb_lo_strap_out(usb_lo_strap));

  smps_top i_smps_top (.clk_in(clk_in), .nrst_in(nrst_in), .enable_in(enable_in),
    .mode_strap_in(mode_strap), .dp_gain_strap_hi_in(dp_hi), .dp_gain_strap_lo_addr_hi_in(dp_lo),
    .usb_down_gain_strap_hi_in(us_hi), .usb_down_gain_strap_lo_addr_lo_in(usb_lo_strap),
    .flip_scl_in(flip_pin), .usb_path_control_sda_in(sda_pin), .dp_path_control_in(dp_pin),
    .reg_flip_in(r_flip), .reg_usb_en_in(r_usb), .reg_dp_en_in(r_dp),
    .aux_pair_pos_in(ax_p), .aux_pair_neg_in(ax_n), .sbu1_out(sbu1), .sbu2_out(sbu2),
    .mode_out(mode), .i2c_active_out(i2c_act), .i2c_scl_out(scl), .i2c_sda_out(sda),
    .i2c_addr_out(addr), .flip_out(flip), .usb_en_out(usb_en), .dp_en_out(dp_en),
    .dp_gain_out(dp_gain), .usb_down_gain_out(us_gain), .aux_snoop_out(snoop),
    .aux_snoop_pos_out(snp_p), .aux_snoop_neg_out(snp_n));

  // ****************************************
  // Reference behaviour
  // ****************************************
  function automatic logic [24:0] model(input logic [1:0] m, dh, dl, uh, ul,
                                        input logic fp, sp, dp, rf, ru, rd, ap, an);
    logic i2c;
    logic f;
    i2c = m != `SMPS_LVL_ZERO;
    f = i2c ? rf : fp;
    return {m, i2c, i2c ? fp : 1'b1, i2c ? sp : 1'b1, i2c ? {dl, ul} : 4'h0, f,
            i2c ? ru : sp, i2c ? rd : dp, dh, dl, uh, ul, i2c, f ? an : ap, f ? ap : an,
            ap, an};
  endfunction

  // Xorshift step; the bench's only source of random values
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #1;
    end
  endtask

  task automatic note(input logic [24:0] v);
    notes.push_back(v);
    -> sample_ev;
  endtask

  // Enable low for a cycle before each rise, as the capture needs
  task automatic strap(input logic [1:0] m, dh, dl, uh, ul);
    mode_req = m;
    dp_hi = dh;
    dp_lo = dl;
    us_hi = uh;
    usb_lo_req = ul;
    tick(1);
    enable_in = 1'b1;
    tick(1);
    enable_in = 1'b0;
    tick(3);
    {cap_m, cap_dh, cap_dl, cap_uh, cap_ul} = {mode_strap, dh, dl, uh, usb_lo_strap};
  endtask

  task automatic pins();
    logic [31:0] r;
    r = rnd();
    {flip_pin, sda_pin, dp_pin, r_flip, r_usb, r_dp, ax_p, ax_n} = r[7:0];
    tick(2);
    note(model(cap_m, cap_dh, cap_dl, cap_uh, cap_ul, flip_pin, sda_pin, dp_pin,
               r_flip, r_usb, r_dp, ax_p, ax_n));
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Watcher and hang guard
  // ****************************************
  always @(sample_ev) begin
    logic [24:0] exp_v;
    exp_v = notes.pop_front();
    n_compared++;
    if (seen !== exp_v) begin
      fail_count++;
      $display("[FAIL] %0t exp %h got %h", $time, exp_v, seen);
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] r;
    tick(8);
    note(25'h0300000);
    tick(2);
    nrst_in = 1'b1;
    tick(3);
    for (int m = 0; m < 4; m++) begin
      repeat (3) begin
        r = rnd();
        strap(m[1:0], r[1:0], r[3:2], r[5:4], r[7:6]);
        repeat (4) pins();
        // Straps move without an enable rise; captured levels must hold
        mode_req = ~mode_req;
        dp_lo = ~dp_lo;
        usb_lo_req = ~usb_lo_req;
        tick(3);
        pins();
      end
    end
    tick(2);
    tally_and_finish();
  end
endmodule
